// [core/ser_cfg_host.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ser_cfg_params.svh"
module ser_cfg_host #(
    parameter int SCLK_HALF = `SCLK_HALF_CYC,
    parameter int PCLK_HALF = `PCLK_HALF_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    ser_cfg_if.host          link,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    ////////////////////////////////////////////////////////////////////
    ser_cfg_pkg::spi_state_t state_r;
    logic [6:0]  addr_r;
    logic [7:0]  wdata_r;
    logic [7:0]  rdata_r;
    logic        three_wire_r, read_r, done_r, refused_r;
    logic        pd_n_r, pclk_run_r, pclk_r;
    logic [7:0]  pclk_cnt_r;
    logic [3:0]  gap_cnt_r;
    logic [7:0]  div_r;
    logic [4:0]  bit_r;
    logic [15:0] tx_r;
    logic        sclk_r, cs_n_r, do_r, oe_r;
    logic        wr_go, start, rsvd;
    logic [31:0] rd_word;

    // reserved targets refused for writes
    assign rsvd  = (addr_r == 7'h01) || (addr_r == `OFS_RSVD_GAP)
                 || (addr_r >= `OFS_RSVD_LO_FIRST
                 && addr_r <= `OFS_RSVD_LO_LAST)
                 || (addr_r > `OFS_UNLOCK_SELECT);
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign start = wr_go && s_axi_awaddr == `CTL_CTRL && s_axi_wdata[0]
                 && state_r == ser_cfg_pkg::SPI_IDLE
                 && !(rsvd && !s_axi_wdata[1]);

    ////////////////////////////////////////////////////////////////////
    // axi write: both channels together, answer next cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
            addr_r       <= 7'h00;
            wdata_r      <= 8'h00;
            three_wire_r <= 1'b0;
            pd_n_r       <= 1'b0;
            pclk_run_r   <= 1'b0;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            unique case (s_axi_awaddr)
                `CTL_CTRL:   if (s_axi_wstrb[0]) three_wire_r <= s_axi_wdata[2];
                `CTL_ADDR:   if (s_axi_wstrb[0]) addr_r <= s_axi_wdata[6:0];
                `CTL_WDATA:  if (s_axi_wstrb[0]) wdata_r <= s_axi_wdata[7:0];
                `CTL_PINS: begin
                    if (s_axi_wstrb[0]) begin
                        pd_n_r     <= s_axi_wdata[0];
                        pclk_run_r <= s_axi_wdata[1];
                    end
                end
                `CTL_STATUS, `CTL_RDATA: ;
                default:     s_axi_bresp <= 2'b10;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;

    // axi read side
    always_comb begin
        unique case (s_axi_araddr)
            `CTL_CTRL:   rd_word = {29'h0, three_wire_r, read_r, 1'b0};
            `CTL_ADDR:   rd_word = {25'h0, addr_r};
            `CTL_WDATA:  rd_word = {24'h0, wdata_r};
            `CTL_STATUS: rd_word = {29'h0, refused_r, done_r,
                                    state_r != ser_cfg_pkg::SPI_IDLE};
            `CTL_RDATA:  rd_word = {24'h0, rdata_r};
            `CTL_PINS:   rd_word = {30'h0, pclk_run_r, pd_n_r};
            default:     rd_word = 32'h0;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= (s_axi_araddr > `CTL_PINS || |s_axi_araddr[1:0])
                          ? 2'b10 : 2'b00;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = s_axi_arvalid & ~s_axi_rvalid;

    ////////////////////////////////////////////////////////////////////
    // pixel clock: stops low, gap of four periods at least
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pclk_r     <= 1'b0;
            pclk_cnt_r <= 8'h00;
            gap_cnt_r  <= 4'h0;
        end else if (pclk_cnt_r != 8'(PCLK_HALF - 1)) begin
            pclk_cnt_r <= pclk_cnt_r + 8'h01;
        end else begin
            pclk_cnt_r <= 8'h00;
            if (pclk_r) begin
                pclk_r <= 1'b0;
            end else if (!pclk_run_r) begin
                gap_cnt_r <= 4'h0;
            end else if (gap_cnt_r != 4'(2 * `PCLK_MIN_GAP_PER)) begin
                gap_cnt_r <= gap_cnt_r + 4'h1;
            end else begin
                pclk_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // serial engine: change on fall, sample on rise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ser_cfg_pkg::SPI_IDLE;
            sclk_r  <= 1'b0;
            cs_n_r  <= 1'b1;
            do_r    <= 1'b0;
            oe_r    <= 1'b0;
            div_r   <= 8'h00;
            bit_r   <= 5'h00;
            tx_r    <= 16'h0000;
            rdata_r <= 8'h00;
            read_r  <= 1'b0;
        end else begin
            unique case (state_r)
                ser_cfg_pkg::SPI_IDLE: begin
                    if (start) begin
                        state_r <= ser_cfg_pkg::SPI_RUN;
                        read_r  <= s_axi_wdata[1];
                        tx_r    <= {s_axi_wdata[1], addr_r, wdata_r};
                        do_r    <= s_axi_wdata[1];
                        oe_r    <= 1'b1;
                        cs_n_r  <= 1'b0;
                        div_r   <= 8'h00;
                        bit_r   <= 5'h00;
                    end
                end
                ser_cfg_pkg::SPI_RUN: begin
                    if (div_r != 8'(SCLK_HALF - 1)) begin
                        div_r <= div_r + 8'h01;
                    end else begin
                        div_r  <= 8'h00;
                        sclk_r <= ~sclk_r;
                        if (!sclk_r) begin
                            bit_r   <= bit_r + 5'h01;
                            rdata_r <= {rdata_r[6:0], link.host_di};
                        end else if (bit_r == 5'(`FRAME_BITS)) begin
                            state_r <= ser_cfg_pkg::SPI_GAP;
                            cs_n_r  <= 1'b1;
                            oe_r    <= 1'b0;
                        end else begin
                            tx_r <= {tx_r[14:0], 1'b0};
                            do_r <= tx_r[14];
                            oe_r <= ~(read_r
                                  && bit_r >= 5'(`HEADER_BITS));
                        end
                    end
                end
                ser_cfg_pkg::SPI_GAP: begin
                    div_r <= div_r + 8'h01;
                    if (div_r == 8'(SCLK_HALF - 1)) begin
                        state_r <= ser_cfg_pkg::SPI_IDLE;
                    end
                end
                default: state_r <= ser_cfg_pkg::SPI_IDLE;
            endcase
        end
    end

    // sticky flags; a new event wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_r    <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            done_r    <= (state_r == ser_cfg_pkg::SPI_GAP)
                       | (done_r & ~start);
            refused_r <= (wr_go && s_axi_awaddr == `CTL_CTRL
                          && s_axi_wdata[0] && rsvd && !s_axi_wdata[1])
                       | (refused_r & ~start);
        end
    end

    assign link.sclk         = sclk_r;
    assign link.cs_n         = cs_n_r;
    assign link.host_do      = do_r;
    assign link.host_oe      = oe_r;
    assign link.three_wire   = three_wire_r;
    assign link.pclk         = pclk_r;
    assign link.power_down_n = pd_n_r;

endmodule : ser_cfg_host
`default_nettype wire

// [core/ser_cfg_params.svh]
`ifndef SER_CFG_PARAMS_SVH
`define SER_CFG_PARAMS_SVH

// device offsets, 7-bit address
`define OFS_COMMAND        7'h00
`define OFS_DITHER_TWO     7'h09
`define OFS_RSVD_GAP       7'h0a
`define OFS_CONFIG_THREE   7'h0b
`define OFS_RSVD_LO_FIRST  7'h0c
`define OFS_RSVD_LO_LAST   7'h15
`define OFS_UNLOCK_SELECT  7'h16

// device register reset values and the unlock select enable value
`define RST_COMMAND        8'h00
`define RST_DITHER_TWO     8'h67
`define RST_CONFIG_THREE   8'h00
`define RST_UNLOCK_SELECT  8'h00
`define UNLOCK_ENABLE_VAL  8'hff

// field positions
`define BIT_LUT_ENABLE     0
`define BIT_SPECIAL_UNLOCK 4
`define BIT_SOFT_RESET     1
`define BIT_MODE24         2

// serial clock multipliers
`define MULT_18BIT         4'h6
`define MULT_24BIT         4'h8

// serial frame geometry
`define FRAME_BITS         16
`define HEADER_BITS        8

// timing counts in aclk cycles, except PCLK_MIN_GAP_PER in pixel clock periods
`define PCLK_STOP_DETECT   32
`define PCLK_MIN_GAP_PER   4
`define SCLK_HALF_CYC      4
`define PCLK_HALF_CYC      2

// controller byte addresses
`define CTL_CTRL           8'h00
`define CTL_ADDR           8'h04
`define CTL_WDATA          8'h08
`define CTL_STATUS         8'h0c
`define CTL_RDATA          8'h10
`define CTL_PINS           8'h14

`endif

// [core/ser_cfg_pkg.sv]
package ser_cfg_pkg;
    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_RUN  = 2'b01,
        SPI_GAP  = 2'b10
    } spi_state_t;

    typedef logic [7:0] cfg_byte_t;
    typedef logic [6:0] cfg_addr_t;
endpackage : ser_cfg_pkg

// [core/ser_cfg_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface ser_cfg_if;
    logic sclk;
    logic cs_n;
    logic host_do;
    logic host_oe;
    logic dev_do;
    logic dev_oe;
    logic three_wire;
    logic pclk;
    logic power_down_n;
    logic sda;
    logic dev_di;
    logic host_di;

    // 3-wire shared line, pulled high when idle
    assign sda     = dev_oe ? dev_do : (host_oe ? host_do : 1'b1);
    assign dev_di  = three_wire ? sda : host_do;
    assign host_di = three_wire ? sda : (dev_oe ? dev_do : 1'b1);

    modport dev  (input sclk, input cs_n, input dev_di, input three_wire,
                  input pclk, input power_down_n,
                  output dev_do, output dev_oe);
    modport host (output sclk, output cs_n, output host_do, output host_oe,
                  output three_wire, output pclk, output power_down_n,
                  input host_di);
endinterface : ser_cfg_if
`default_nettype wire

// [core/serializer_side.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ser_cfg_params.svh"
module serializer_side #(
    parameter int STOP_DETECT = `PCLK_STOP_DETECT
) (
    input  wire logic           aclk,
    input  wire logic           aresetn,
    ser_cfg_if.dev              link,
    output logic                sleep,
    output logic                core_reset,
    output logic                lut_enable,
    output logic [3:0]          serial_mult,
    output logic [7:0]          dither_two
);

    ////////////////////////////////////////////////////////////////////
    // registers and serial state
    ser_cfg_pkg::cfg_byte_t command_r;
    ser_cfg_pkg::cfg_byte_t dither_two_r;
    ser_cfg_pkg::cfg_byte_t config_three_r;
    ser_cfg_pkg::cfg_byte_t unlock_select_r;
    logic                   sclk_q_r;
    logic [4:0]             bit_cnt_r;
    logic [15:0]            shift_r;
    logic [7:0]             out_r;
    logic                   rd_pend_r;
    logic                   dev_do_r;
    logic                   dev_oe_r;
    logic                   pclk_q_r;
    logic [15:0]            idle_cnt_r;
    logic                   pclk_stopped_r;
    logic                   sleep_r;
    logic                   core_reset_r;
    logic                   lut_enable_r;
    logic [3:0]             serial_mult_r;
    logic                   sclk_rise;
    logic                   sclk_fall;
    logic                   spi_enabled;
    logic                   special_open;
    logic                   wr_commit;
    logic                   rd_start;
    ser_cfg_pkg::cfg_addr_t wr_addr;
    ser_cfg_pkg::cfg_byte_t wr_data;
    ser_cfg_pkg::cfg_addr_t rd_addr;
    ser_cfg_pkg::cfg_byte_t rd_value;

    ////////////////////////////////////////////////////////////////////
    // decode of the serial frame
    assign sclk_rise    = link.sclk & ~sclk_q_r;
    assign sclk_fall    = ~link.sclk & sclk_q_r;
    assign spi_enabled  = (unlock_select_r == `UNLOCK_ENABLE_VAL);
    assign special_open = command_r[`BIT_SPECIAL_UNLOCK];
    assign wr_commit    = ~link.cs_n & sclk_rise
                        & (bit_cnt_r == 5'(`FRAME_BITS - 1)) & ~shift_r[14];
    assign rd_start     = ~link.cs_n & sclk_rise
                        & (bit_cnt_r == 5'(`HEADER_BITS - 1)) & shift_r[6];
    assign wr_addr      = shift_r[13:7];
    assign wr_data      = {shift_r[6:0], link.dev_di};
    assign rd_addr      = {shift_r[5:0], link.dev_di};

    // readback: protected registers give no data
    always_comb begin
        unique case (rd_addr)
            `OFS_COMMAND:       rd_value = command_r;
            `OFS_UNLOCK_SELECT: rd_value = unlock_select_r;
            default:            rd_value = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // sampled sclk for edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_q_r <= 1'b0;
        end else begin
            sclk_q_r <= link.sclk;
        end
    end

    // bit counter and input shifter
    always_ff @(posedge aclk) begin
        if (!aresetn || link.cs_n) begin
            bit_cnt_r <= 5'h00;
            shift_r   <= 16'h0000;
        end else if (sclk_rise && bit_cnt_r != 5'(`FRAME_BITS)) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
            shift_r   <= {shift_r[14:0], link.dev_di};
        end
    end

    // read answer on falls after the header
    always_ff @(posedge aclk) begin
        if (!aresetn || link.cs_n) begin
            out_r     <= 8'h00;
            rd_pend_r <= 1'b0;
            dev_do_r  <= 1'b0;
            dev_oe_r  <= 1'b0;
        end else if (rd_start) begin
            out_r     <= rd_value;
            rd_pend_r <= spi_enabled;
        end else if (sclk_fall && rd_pend_r) begin
            dev_oe_r  <= 1'b1;
            dev_do_r  <= out_r[7];
            out_r     <= {out_r[6:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pixel clock activity watch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pclk_q_r       <= 1'b0;
            idle_cnt_r     <= 16'h0000;
            pclk_stopped_r <= 1'b0;
        end else begin
            pclk_q_r <= link.pclk;
            if (link.pclk != pclk_q_r) begin
                idle_cnt_r     <= 16'h0000;
                pclk_stopped_r <= 1'b0;
            end else if (idle_cnt_r == 16'(STOP_DETECT)) begin
                pclk_stopped_r <= link.power_down_n;
            end else begin
                idle_cnt_r <= idle_cnt_r + 16'h0001;
            end
        end
    end

    // sleep state from either entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_r <= 1'b1;
        end else begin
            sleep_r <= ~link.power_down_n | pclk_stopped_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // config registers, kept by clock-stop sleep
    always_ff @(posedge aclk) begin
        if (!aresetn || !link.power_down_n) begin
            command_r       <= `RST_COMMAND;
            dither_two_r    <= `RST_DITHER_TWO;
            config_three_r  <= `RST_CONFIG_THREE;
            unlock_select_r <= `RST_UNLOCK_SELECT;
        end else if (wr_commit) begin
            if (wr_addr == `OFS_UNLOCK_SELECT) begin
                unlock_select_r <= wr_data;
            end else if (spi_enabled) begin
                if (wr_addr == `OFS_COMMAND) begin
                    command_r <= wr_data;
                end
                if (wr_addr == `OFS_DITHER_TWO && special_open) begin
                    dither_two_r <= wr_data;
                end
                if (wr_addr == `OFS_CONFIG_THREE && special_open) begin
                    config_three_r <= wr_data;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered control outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_reset_r  <= 1'b1;
            lut_enable_r  <= 1'b0;
            serial_mult_r <= `MULT_18BIT;
        end else begin
            core_reset_r  <= config_three_r[`BIT_SOFT_RESET];
            lut_enable_r  <= command_r[`BIT_LUT_ENABLE];
            serial_mult_r <= config_three_r[`BIT_MODE24]
                           ? `MULT_24BIT : `MULT_18BIT;
        end
    end

    assign link.dev_do = dev_do_r;
    assign link.dev_oe = dev_oe_r;
    assign sleep       = sleep_r;
    assign core_reset  = core_reset_r;
    assign lut_enable  = lut_enable_r;
    assign serial_mult = serial_mult_r;
    assign dither_two  = dither_two_r;

endmodule : serializer_side
`default_nettype wire

// [tb/ser_cfg_link_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module ser_cfg_link_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic host_oe,
    input wire logic dev_oe,
    input wire logic three_wire,
    input wire logic pclk,
    input wire logic power_down_n
);
    logic [4:0] rise_cnt_r;
    logic [4:0] low_cnt_r;
    logic       sclk_r;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////
    // sclk rises in this frame
    always_ff @(posedge aclk) begin
        if (!aresetn || cs_n) begin
            rise_cnt_r <= 5'h00;
        end else if (sclk && !sclk_r) begin
            rise_cnt_r <= rise_cnt_r + 5'h01;
        end
    end

    // last sclk level
    always_ff @(posedge aclk) begin
        sclk_r <= aresetn ? sclk : 1'b0;
    end

    // pixel clock low-phase length, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn || pclk) begin
            low_cnt_r <= 5'h00;
        end else if (low_cnt_r != 5'h1f) begin
            low_cnt_r <= low_cnt_r + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    no_contention_a : assert property (
        three_wire |-> !(dev_oe && host_oe)) else $error("line contention");
    turnaround_a : assert property ($rose(dev_oe) && three_wire |->
        !host_oe && !$past(host_oe)) else $error("early turnaround");
    dev_release_a : assert property (cs_n && $past(cs_n) |-> !dev_oe)
        else $error("drive after frame");
    sleep_quiet_a : assert property (!power_down_n [*3] |-> !dev_oe)
        else $error("drives in sleep");
    frame_len_a : assert property ($rose(cs_n) |-> rise_cnt_r == 5'h10)
        else $error("bad frame length");
    sclk_idle_a : assert property (cs_n |-> !sclk)
        else $error("sclk high while idle");
    frame_start_a : assert property ($fell(cs_n) |-> !sclk ##1 !sclk)
        else $error("sclk rose early");
    host_release_a : assert property (host_oe |-> !cs_n)
        else $error("host drives deselected");
    stop_gap_a : assert property ($rose(pclk) |->
        low_cnt_r <= 5'h02 || low_cnt_r >= 5'h0f)
        else $error("stop gap short");

    cover property ($rose(dev_oe) && three_wire);
    cover property ($rose(dev_oe) && !three_wire);
    cover property ($rose(pclk) && low_cnt_r >= 5'h0f);
    cover property ($fell(power_down_n));
endmodule : ser_cfg_link_asserts
`default_nettype wire

// [tb/serializer_config_power_ctl_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ser_cfg_params.svh"
module serializer_config_power_ctl_bench;
    typedef struct packed {logic [33:0] mask; logic [33:0] val;} note_t;
    localparam logic [33:0] NONE = 34'h0;
    localparam logic [33:0] BYTE = 34'h3_0000_00ff;
    localparam logic [3:0]  M6   = `MULT_18BIT;
    localparam logic [3:0]  M8   = `MULT_24BIT;
    localparam logic [7:0]  DEF  = `RST_DITHER_TWO;
    logic        aclk, aresetn, snap, sleep, core_reset, lut_enable;
    logic [7:0]  awaddr, araddr, dither_two, dval;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd_last, seed;
    logic [3:0]  wstrb, serial_mult;
    logic [1:0]  bresp, rresp;
    note_t       q[$];
    int          errors, num_checks;

    ser_cfg_if link_if ();
    serializer_side #(.STOP_DETECT(8)) serializer_side_inst (
        .aclk(aclk), .aresetn(aresetn), .link(link_if.dev), .sleep(sleep),
        .core_reset(core_reset), .lut_enable(lut_enable),
        .serial_mult(serial_mult), .dither_two(dither_two));
    ser_cfg_host #(.SCLK_HALF(2), .PCLK_HALF(2)) ser_cfg_host_inst (
        .aclk(aclk), .aresetn(aresetn), .link(link_if.host),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    ser_cfg_link_asserts ser_cfg_link_asserts_inst (
        .aclk(aclk), .aresetn(aresetn), .sclk(link_if.sclk),
        .cs_n(link_if.cs_n), .host_oe(link_if.host_oe),
        .dev_oe(link_if.dev_oe), .three_wire(link_if.three_wire),
        .pclk(link_if.pclk), .power_down_n(link_if.power_down_n));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
        input logic [33:0] m, input logic [33:0] v);
        q.push_back('{m, v});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [33:0] m,
        input logic [33:0] v);
        q.push_back('{m, v});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rd_last = rdata;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd

    // one serial frame, waits for done
    task automatic dev_op(input logic rd, input logic tw, input logic [6:0] a,
        input logic [7:0] d, input logic [33:0] v);
        axi_wr(`CTL_ADDR, {25'h0, a}, NONE, NONE);
        axi_wr(`CTL_WDATA, {24'h0, d}, NONE, NONE);
        axi_wr(`CTL_CTRL, {29'h0, tw, rd, 1'b1}, NONE, NONE);
        do axi_rd(`CTL_STATUS, NONE, NONE); while (rd_last[1] !== 1'b1);
        if (rd) axi_rd(`CTL_RDATA, BYTE, v);
    endtask : dev_op

    task automatic wr3(input logic [6:0] a, input logic [7:0] d);
        dev_op(1'b0, 1'b1, a, d, NONE);
    endtask : wr3

    // snapshot of the device outputs
    task automatic peek(input logic s, input logic c, input logic l,
        input logic [3:0] m, input logic [7:0] d);
        q.push_back('{34'h7fff, {19'h0, s, c, l, m, d}});
        snap <= 1'b1;
        @(posedge aclk);
        snap <= 1'b0;
        @(posedge aclk);
    endtask : peek

    ////////////////////////////////////////////////////////////////////////
    // compares each result with the oldest note
    task automatic check(input logic [33:0] got);
        note_t n;
        n = q.pop_front();
        if (n.mask != NONE) begin
            num_checks++;
            if ((got & n.mask) !== n.val) begin
                errors++;
                $display("MISMATCH at %0t: got %h expected %h", $time,
                    got & n.mask, n.val);
            end
        end
    endtask : check

    always @(posedge aclk) begin
        if (rvalid && rready) check({rresp, rdata});
        else if (bvalid && bready) check({bresp, 32'h0});
        else if (snap) check({19'h0, sleep, core_reset, lut_enable,
            serial_mult, dither_two});
    end

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    initial begin
        repeat (40000) @(posedge aclk);
        errors++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, snap, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'h1;
        errors = 0;
        num_checks = 0;
        seed = 32'h3ec9;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        peek(1'b1, 1'b0, 1'b0, M6, DEF);
        axi_rd(8'h18, 34'h3_ffff_ffff, 34'h2_0000_0000);
        axi_wr(8'h1c, 32'h0, 34'h3_0000_0000, 34'h2_0000_0000);
        axi_wr(`CTL_PINS, 32'h3, NONE, NONE);
        repeat (40) @(posedge aclk);
        peek(1'b0, 1'b0, 1'b0, M6, DEF);
        $display("finished reset and wake");
        wr3(`OFS_COMMAND, 8'h01);
        peek(1'b0, 1'b0, 1'b0, M6, DEF);
        dev_op(1'b1, 1'b1, `OFS_UNLOCK_SELECT, 8'h00, 34'hff);
        dev_op(1'b0, 1'b0, `OFS_UNLOCK_SELECT, 8'hff, NONE);
        wr3(`OFS_COMMAND, 8'h01);
        peek(1'b0, 1'b0, 1'b1, M6, DEF);
        dev_op(1'b1, 1'b1, `OFS_COMMAND, 8'h00, 34'h01);
        dev_op(1'b1, 1'b0, `OFS_COMMAND, 8'h00, 34'h01);
        wr3(`OFS_UNLOCK_SELECT, 8'hfe);
        wr3(`OFS_COMMAND, 8'h00);
        peek(1'b0, 1'b0, 1'b1, M6, DEF);
        wr3(`OFS_UNLOCK_SELECT, 8'hff);
        $display("finished select lock");
        seed = xorshift(seed);
        dval = seed[7:0] | 8'h80;
        wr3(`OFS_DITHER_TWO, dval);
        peek(1'b0, 1'b0, 1'b1, M6, DEF);
        wr3(`OFS_COMMAND, 8'h11);
        wr3(`OFS_DITHER_TWO, dval);
        peek(1'b0, 1'b0, 1'b1, M6, dval);
        dev_op(1'b1, 1'b1, `OFS_DITHER_TWO, 8'h00, 34'h00);
        wr3(`OFS_CONFIG_THREE, 8'h04);
        peek(1'b0, 1'b0, 1'b1, M8, dval);
        wr3(`OFS_CONFIG_THREE, 8'h02);
        peek(1'b0, 1'b1, 1'b1, M6, dval);
        wr3(`OFS_CONFIG_THREE, 8'h00);
        peek(1'b0, 1'b0, 1'b1, M6, dval);
        $display("finished special access");
        axi_wr(`CTL_ADDR, {25'h0, `OFS_RSVD_GAP}, NONE, NONE);
        axi_wr(`CTL_CTRL, 32'h1, NONE, NONE);
        repeat (4) @(posedge aclk);
        axi_rd(`CTL_STATUS, 34'h4, 34'h4);
        repeat (200) @(posedge aclk);
        axi_wr(`CTL_PINS, 32'h1, NONE, NONE);
        repeat (40) @(posedge aclk);
        peek(1'b1, 1'b0, 1'b1, M6, dval);
        axi_wr(`CTL_PINS, 32'h3, NONE, NONE);
        repeat (40) @(posedge aclk);
        peek(1'b0, 1'b0, 1'b1, M6, dval);
        axi_wr(`CTL_PINS, 32'h2, NONE, NONE);
        repeat (4) @(posedge aclk);
        peek(1'b1, 1'b0, 1'b0, M6, DEF);
        axi_wr(`CTL_PINS, 32'h3, NONE, NONE);
        repeat (40) @(posedge aclk);
        peek(1'b0, 1'b0, 1'b0, M6, DEF);
        $display("finished sleep modes");
        stop_test();
    end
endmodule : serializer_config_power_ctl_bench
`default_nettype wire
